// >>> hw/swt_defines.vh
// swt_defines.vh: constants for the stairwell / dual-function timer
// assumes: included by the timer modules; definitions only
`ifndef SWT_DEFINES_VH
`define SWT_DEFINES_VH

// register offsets
`define SWT_REG_CTRL 4'h0
`define SWT_REG_DELAY 4'h1
`define SWT_REG_LONG 4'h2
`define SWT_REG_STATUS 4'h3
`define SWT_REG_ELAPSED 4'h4
`define SWT_REG_CYCLE 4'h5

// control field positions
`define SWT_CTRL_MODE 0
`define SWT_CTRL_BASE_LO 1
`define SWT_CTRL_BASE_HI 2
`define SWT_CTRL_EN 3

// reset values
`define SWT_CTRL_RST 4'h3
`define SWT_DELAY_RST 16'h0003
`define SWT_LONG_RST 16'h0002
`define SWT_CYCLE_RST 16'h000a

// modes and time bases
`define SWT_MODE_STAIR 1'b0
`define SWT_MODE_DUAL 1'b1
`define SWT_BASE_SEC 2'h0
`define SWT_BASE_MIN 2'h1
`define SWT_BASE_HOUR 2'h2

// time base ticks in units of 50 ms, warning offset and blink in ticks
`define SWT_TICK_MS 50
`define SWT_CLK_MHZ 250
`define SWT_SEC_TICKS 20
`define SWT_MIN_TICKS 1200
`define SWT_HOUR_TICKS 72000
`define SWT_WARN_SEC 15
`define SWT_BLINK_SEC 1
`define SWT_WARN_MIN 300
`define SWT_BLINK_MIN 20
`define SWT_WARN_HOUR 18000
`define SWT_BLINK_HOUR 1200
`define SWT_CYCLE_LIMIT_MS 25

`endif

// >>> hw/swt_tick.v
// swt_tick.v: divider making a one-cycle 50 ms enable pulse
// assumes: single clock at 250 MHz, async active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "swt_defines.vh"

module swt_tick #(
    parameter integer TICK_CYCLES = `SWT_TICK_MS * 1000 * `SWT_CLK_MHZ
) (
    input wire clk_i,
    input wire nrst_i,
    input wire run_i,
    output reg tick_o
);
    reg [31:0] cnt_q;

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end
        else if (cnt_q == TICK_CYCLES - 1)
        begin
            cnt_q <= 32'h0;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> hw/swt_timer.v
// swt_timer.v: stairwell light and dual-function switch timer
// assumes: trigger from a pin, registers on a plain strobe port
// Operation
// RULE1: stairwell: trigger falling edge zeroes elapsed time, output high
// RULE2: minutes base: output low 1 s, starting 15 s before expiry
// RULE3: stairwell: elapsed reaching delay clears output
// RULE4: stairwell: new trigger while running restarts elapsed time
// RULE5: reset (power loss) clears elapsed time in both modes
// RULE6: warning offset and blink follow the selected time base
// RULE7: seconds base only honoured when cycle time below 25 ms
// RULE8: time base resets to minutes
// RULE9: dual: trigger rising edge starts elapsed time, output high
// RULE10: dual: elapsed reaching hold time clears output unless permanent
// RULE11: dual: trigger held for long-press time enters permanent on
// RULE12: dual: further trigger while on clears output and permanent
// RULE13: elapsed counter runs on base tick, compared with registers
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "swt_defines.vh"

module swt_timer #(
    parameter integer TICK_CYCLES = `SWT_TICK_MS * 1000 * `SWT_CLK_MHZ,
    parameter integer CNT_W = 32
) (
    input wire clk_i,
    input wire nrst_i,
    input wire trig_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    output reg switch_o
);
    reg trig_s1_q;
    reg trig_s2_q;
    reg trig_prev_q;
    reg [3:0] ctrl_q;
    reg [15:0] delay_q;
    reg [15:0] long_q;
    reg [15:0] cycle_q;
    reg [CNT_W-1:0] elapsed_q;
    reg [CNT_W-1:0] press_q;
    reg running_q;
    reg perm_q;
    wire tick;
    wire mode;
    wire [1:0] base;
    wire [1:0] eff_base;
    wire rise;
    wire fall;
    reg [CNT_W-1:0] unit_ticks;
    reg [CNT_W-1:0] warn_ticks;
    reg [CNT_W-1:0] blink_ticks;
    reg [CNT_W-1:0] delay_ticks;
    reg [CNT_W-1:0] long_ticks;
    reg in_warn;

    assign mode = ctrl_q[`SWT_CTRL_MODE];
    assign base = ctrl_q[`SWT_CTRL_BASE_HI:`SWT_CTRL_BASE_LO];
    // RULE7: seconds gated
    assign eff_base = (base == `SWT_BASE_SEC && cycle_q >= `SWT_CYCLE_LIMIT_MS)
        ? `SWT_BASE_MIN : base;
    assign rise = trig_s2_q & ~trig_prev_q;
    assign fall = ~trig_s2_q & trig_prev_q;

    swt_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .run_i(ctrl_q[`SWT_CTRL_EN]),
        .tick_o(tick)
    );

    // RULE6: per-base scaling
    always @*
    begin
        case (eff_base)
            `SWT_BASE_SEC:
            begin
                unit_ticks = `SWT_SEC_TICKS;
                warn_ticks = `SWT_WARN_SEC;
                blink_ticks = `SWT_BLINK_SEC;
            end
            `SWT_BASE_HOUR:
            begin
                unit_ticks = `SWT_HOUR_TICKS;
                warn_ticks = `SWT_WARN_HOUR;
                blink_ticks = `SWT_BLINK_HOUR;
            end
            default:
            begin
                unit_ticks = `SWT_MIN_TICKS;
                warn_ticks = `SWT_WARN_MIN;
                blink_ticks = `SWT_BLINK_MIN;
            end
        endcase
        delay_ticks = unit_ticks * {{(CNT_W-16){1'b0}}, delay_q};
        long_ticks = unit_ticks * {{(CNT_W-16){1'b0}}, long_q};
    end

    // RULE2: warning window
    always @*
    begin
        in_warn = 1'b0;
        if (mode == `SWT_MODE_STAIR && delay_ticks > warn_ticks)
        begin
            in_warn = (elapsed_q >= delay_ticks - warn_ticks) &&
                (elapsed_q < delay_ticks - warn_ticks + blink_ticks);
        end
    end

    // trigger synchroniser
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end
        else
        begin
            trig_s1_q <= trig_i;
            trig_s2_q <= trig_s1_q;
            trig_prev_q <= trig_s2_q;
        end
    end

    // register writes
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // RULE8: minutes default
            ctrl_q <= `SWT_CTRL_RST;
            delay_q <= `SWT_DELAY_RST;
            long_q <= `SWT_LONG_RST;
            cycle_q <= `SWT_CYCLE_RST;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `SWT_REG_CTRL: ctrl_q <= wdata_i[3:0];
                `SWT_REG_DELAY: delay_q <= wdata_i;
                `SWT_REG_LONG: long_q <= wdata_i;
                `SWT_REG_CYCLE: cycle_q <= wdata_i;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // timer core
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // RULE5: power loss clears
            elapsed_q <= {CNT_W{1'b0}};
            press_q <= {CNT_W{1'b0}};
            running_q <= 1'b0;
            perm_q <= 1'b0;
            switch_o <= 1'b0;
        end
        else if (mode == `SWT_MODE_STAIR)
        begin
            perm_q <= 1'b0;
            press_q <= {CNT_W{1'b0}};
            if (fall)
            begin
                // RULE1: falling edge starts
                // RULE4: retrigger restarts
                elapsed_q <= {CNT_W{1'b0}};
                running_q <= 1'b1;
                switch_o <= 1'b1;
            end
            else if (running_q)
            begin
                // RULE13: tick counting
                if (elapsed_q >= delay_ticks)
                begin
                    // RULE3: expiry clears
                    running_q <= 1'b0;
                    switch_o <= 1'b0;
                end
                else
                begin
                    if (tick)
                        elapsed_q <= elapsed_q + {{(CNT_W-1){1'b0}}, 1'b1};
                    // RULE2: warning blink
                    switch_o <= ~in_warn;
                end
            end
            else
                switch_o <= 1'b0;
        end
        else
        begin
            if (rise && (running_q || perm_q))
            begin
                // RULE12: next trigger cancels
                running_q <= 1'b0;
                perm_q <= 1'b0;
                elapsed_q <= {CNT_W{1'b0}};
                press_q <= {CNT_W{1'b0}};
                switch_o <= 1'b0;
            end
            else if (rise)
            begin
                // RULE9: rising edge starts
                elapsed_q <= {CNT_W{1'b0}};
                press_q <= {CNT_W{1'b0}};
                running_q <= 1'b1;
                switch_o <= 1'b1;
            end
            else if (running_q)
            begin
                if (trig_s2_q && tick)
                    press_q <= press_q + {{(CNT_W-1){1'b0}}, 1'b1};
                if (!trig_s2_q)
                    press_q <= {CNT_W{1'b0}};
                if (trig_s2_q && press_q >= long_ticks)
                begin
                    // RULE11: long press latches on
                    perm_q <= 1'b1;
                    running_q <= 1'b0;
                    switch_o <= 1'b1;
                end
                else if (elapsed_q >= delay_ticks)
                begin
                    // RULE10: hold expiry
                    running_q <= 1'b0;
                    switch_o <= 1'b0;
                end
                else if (tick)
                    elapsed_q <= elapsed_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            else
                switch_o <= perm_q;
        end
    end

    // register reads
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= 16'h0;
        else if (rd_i)
        begin
            case (addr_i)
                `SWT_REG_CTRL: rdata_o <= {12'h0, ctrl_q};
                `SWT_REG_DELAY: rdata_o <= delay_q;
                `SWT_REG_LONG: rdata_o <= long_q;
                `SWT_REG_STATUS: rdata_o <= {11'h0, eff_base, perm_q, running_q, switch_o};
                `SWT_REG_ELAPSED: rdata_o <= elapsed_q[15:0];
                `SWT_REG_CYCLE: rdata_o <= cycle_q;
                default: rdata_o <= 16'h0;
            endcase
        end
        else
            rdata_o <= 16'h0;
    end
endmodule
`default_nettype wire

// >>> testbench/swt_timer_asserts.sv
// swt_timer_asserts.sv: port checker for swt_timer
// assumes: ctrl reset value and register map of swt_defines.vh
`timescale 1ns/10ps
`default_nettype none
`include "swt_defines.vh"
module swt_chk #(
    parameter integer TICK_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic trig_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic switch_o
);
    logic [3:0] ctrl_q;
    logic [15:0] low_q;
    wire stair = !ctrl_q[0] && ctrl_q[3];
    wire dual = ctrl_q[0] && ctrl_q[3];
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            ctrl_q <= `SWT_CTRL_RST;
            low_q <= 16'h0;
        end
        else
        begin
            if (wr_i && addr_i == `SWT_REG_CTRL)
                ctrl_q <= wdata_i[3:0];
            low_q <= switch_o ? 16'h0 : low_q + 16'h1;
        end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
        else $error("read data not idle");
    a_reset_off: assert property ($rose(nrst_i) |-> !switch_o)
        else $error("output on after reset");
    a_stair_start: assert property (stair && $fell(trig_i) |-> ##4 switch_o)
        else $error("no start on falling trigger");
    a_dual_start: assert property (
        dual && $rose(trig_i) && !switch_o ##2 !switch_o |-> ##1 switch_o)
        else $error("no start on rising trigger");
    a_dual_cancel: assert property (
        dual && $rose(trig_i) && switch_o ##2 switch_o |-> ##1 !switch_o)
        else $error("no cancel on second trigger");
    a_ctrl_readback: assert property (
        wr_i && addr_i == `SWT_REG_CTRL ##2 rd_i && addr_i == `SWT_REG_CTRL
        |-> ##1 rdata_o[3:0] == $past(wdata_i[3:0], 3))
        else $error("ctrl not read back");
    a_blink_len: assert property (
        stair && $rose(switch_o) && low_q < 16'(2 * TICK_CYCLES)
        |-> low_q == 16'(TICK_CYCLES))
        else $error("warning blink length wrong");
    a_stair_hold: assert property (stair && $rose(switch_o) |-> switch_o [*8])
        else $error("output dropped too soon");
endmodule
bind swt_timer swt_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .trig_i(trig_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .switch_o(switch_o));
`default_nettype wire

// >>> testbench/swt_trig_src.sv
// swt_trig_src.sv: trigger level source in place of program logic
// assumes: bench clock; level changes just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module swt_trig_src (
    input wire logic clk_i,
    output logic trig_o
);
    initial trig_o = 1'b0;
    task automatic put(input logic lvl, input int hold);
        @(posedge clk_i);
        trig_o <= lvl;
        repeat (hold) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_swt_timer.sv
// tb_swt_timer.sv: scenario bench for swt_timer
// assumes: TICK_CYCLES cut to 4, so one second is 80 clocks
`timescale 1ns/10ps
`default_nettype none
`include "swt_defines.vh"
module tb_swt_timer;
    logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0;
    wire logic [15:0] rdata_o;
    wire logic trig, switch_o;
    int failures = 0, check_count = 0;
    swt_trig_src src (.clk_i(clk_i), .trig_o(trig));
    swt_timer #(.TICK_CYCLES(4)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .trig_i(trig),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .switch_o(switch_o));
    initial forever #2 clk_i = ~clk_i;
    task automatic wrap_up;
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask
    // waits for switch_o to reach lvl, expecting lo to hi-1 clocks
    task automatic ws(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (switch_o !== lvl && n < hi)
        begin
            @(negedge clk_i);
            n++;
        end
        chk({15'h0, n >= lo && n < hi}, 16'h1);
        if (n >= hi)
            wrap_up();
    endtask
    task automatic s_reset_vals;
        rd(`SWT_REG_CTRL, `SWT_CTRL_RST);
        rd(`SWT_REG_DELAY, `SWT_DELAY_RST);
        rd(`SWT_REG_LONG, `SWT_LONG_RST);
        rd(`SWT_REG_CYCLE, `SWT_CYCLE_RST);
        rd(`SWT_REG_STATUS, 16'h0008);
        rd(4'hf, 16'h0);
    endtask
    task automatic s_stair;
        wr(`SWT_REG_DELAY, 16'h2);
        wr(`SWT_REG_CTRL, 16'h8);
        rd(`SWT_REG_CTRL, 16'h8);
        src.put(1'b1, 5);
        src.put(1'b0, 0);
        ws(1'b1, 3, 7);
        ws(1'b0, 85, 110);
        ws(1'b1, 2, 7);
        ws(1'b0, 45, 70);
    endtask
    task automatic s_retrig;
        src.put(1'b1, 20);
        src.put(1'b0, 60);
        src.put(1'b1, 2);
        src.put(1'b0, 0);
        ws(1'b0, 85, 110);
        ws(1'b1, 2, 7);
        ws(1'b0, 45, 70);
    endtask
    task automatic s_minutes;
        wr(`SWT_REG_DELAY, 16'h1);
        wr(`SWT_REG_CTRL, 16'ha);
        src.put(1'b1, 5);
        src.put(1'b0, 0);
        ws(1'b1, 3, 7);
        ws(1'b0, 3550, 3610);
        ws(1'b1, 70, 90);
        ws(1'b0, 1100, 1140);
    endtask
    task automatic s_cycle;
        wr(`SWT_REG_CYCLE, 16'd25);
        wr(`SWT_REG_CTRL, 16'h8);
        rd(`SWT_REG_STATUS, 16'h0008);
        wr(`SWT_REG_CYCLE, 16'd24);
        rd(`SWT_REG_STATUS, 16'h0000);
        wr(`SWT_REG_CTRL, 16'hc);
        rd(`SWT_REG_STATUS, 16'h0010);
    endtask
    task automatic s_power;
        src.put(1'b1, 5);
        src.put(1'b0, 40);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk({15'h0, switch_o}, 16'h0);
        rd(`SWT_REG_ELAPSED, 16'h0);
        rd(`SWT_REG_CTRL, `SWT_CTRL_RST);
    endtask
    task automatic s_dual;
        wr(`SWT_REG_DELAY, 16'h2);
        wr(`SWT_REG_LONG, 16'h1);
        wr(`SWT_REG_CTRL, 16'h9);
        src.put(1'b1, 10);
        src.put(1'b0, 0);
        ws(1'b1, 0, 2);
        ws(1'b0, 140, 165);
        src.put(1'b1, 120);
        src.put(1'b0, 400);
        @(negedge clk_i);
        chk({15'h0, switch_o}, 16'h1);
        src.put(1'b1, 0);
        ws(1'b0, 2, 7);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        s_reset_vals();
        s_stair();
        s_retrig();
        s_minutes();
        s_cycle();
        s_power();
        s_dual();
        wrap_up();
    end
endmodule
`default_nettype wire
